// ---- design/coc_option_ctrl.sv ----
// Charger option control register with comparator and discharge control
`timescale 1ns/1ps

// Overview of operation
// - Bit 7 forces fixed 27V overvoltage threshold
// - Polarity bit selects comparator output sense
// - Deglitch delays only falling comparator edges
// - Deglitch code picks 1us/40us, ms, s delays
// - Trip with force-off opens both power switches
// - Force-off also pulls charge-ok low
// - Force-off needs comparator enable and valid mode
// - Pass-through bit enables mode, then self-clears
// - Ship bit sinks sense node for 340 ms
// - Window end clears ship bit automatically
// - Host writing zero stops discharge at once
// - Discharge current stops when node reaches 0V
// - Bit 0 enables input short protection, resets on
// - Separate enable runs comparator in low power
module coc_option_ctrl
  import coc_pkg::*;
#(
  parameter int DEG_MID_LIMIT  = DEG_MID_CYCLES,
  parameter int DEG_SLOW_LIMIT = DEG_SLOW_CYCLES,
  parameter int DEG_LONG_LIMIT = DEG_LONG_CYCLES,
  parameter int DCHG_LIMIT     = SHIP_DCHG_CYCLES
)
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       reg_reset,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       comparator_input,
  input  wire logic       comparator_enable,
  input  wire logic       low_power_mode_enable,
  input  wire logic       low_power_comparator_enable,
  input  wire logic       forward_mode,
  input  wire logic       adapter_present,
  input  wire logic       charge_ok_source,
  input  wire logic [2:0] cell_count_present_pin,
  input  wire logic       pass_through_exit,
  input  wire logic       sense_node_at_zero,
  output logic            comparator_output,
  output logic            input_high_side_switch_off,
  output logic            output_high_side_switch_off,
  output logic            charge_ok_indication,
  output logic      [2:0] system_overvoltage_protect,
  output logic            pass_through_mode,
  output logic            ship_discharge_sink,
  output logic            input_short_protect_enable
);

  // ==========================================================
  // Deglitch length from code and power mode
  function automatic logic [31:0] deg_limit(input coc_deg_t code,
                                            input logic     low_pwr);
    logic [31:0] lim;
    lim = 32'(DEG_FAST_CYCLES);
    case (code)
      COC_DEG_FAST: lim = low_pwr ? 32'(DEG_LP_CYCLES)
                                  : 32'(DEG_FAST_CYCLES);
      COC_DEG_MID:  lim = 32'(DEG_MID_LIMIT);
      COC_DEG_SLOW: lim = 32'(DEG_SLOW_LIMIT);
      COC_DEG_LONG: lim = 32'(DEG_LONG_LIMIT);
      default:      lim = 32'(DEG_FAST_CYCLES);
    endcase
    return lim;
  endfunction : deg_limit

  // ==========================================================
  // Register state
  logic [7:0] option;
  logic [7:0] next_option;
  logic [7:0] rdata_q;
  logic [7:0] next_rdata;
  logic       ptm_level;
  logic       next_ptm_level;

  logic       addr_hit;
  logic       wr_hit;
  logic       ship_write_one;
  logic       ship_write_zero;

  coc_link_if link ();

  assign addr_hit        = (reg_addr == COC_REG_OFFSET);
  assign wr_hit          = reg_write && addr_hit;
  assign ship_write_one  = wr_hit && reg_wdata[COC_BIT_SHIP_DCHG];
  assign ship_write_zero = wr_hit && !reg_wdata[COC_BIT_SHIP_DCHG];

  // ==========================================================
  // Register next state
  always_comb
  begin
    next_option = option;
    // Pass-through request is taken in one cycle, then drops
    next_option[COC_BIT_PASS_THRU] = 1'b0;
    if (link.dchg_done)
    begin
      next_option[COC_BIT_SHIP_DCHG] = 1'b0;
    end
    // Host write follows the self-clears so a set beats them; reset comes last
    if (wr_hit)
    begin
      next_option = reg_wdata;
    end
    if (reg_reset)
    begin
      next_option = COC_REG_RESET;
    end
  end

  // ==========================================================
  // Read path
  always_comb
  begin
    next_rdata = rdata_q;
    if (reg_read && addr_hit)
    begin
      next_rdata = option;
    end
    else if (reg_read)
    begin
      next_rdata = COC_READ_MISS;
    end
  end

  // ==========================================================
  // Pass-through mode level, held until the converter exits or a register reset
  always_comb
  begin
    next_ptm_level = ptm_level;
    if (option[COC_BIT_PASS_THRU])
    begin
      next_ptm_level = 1'b1;
    end
    else if (pass_through_exit || reg_reset)
    begin
      next_ptm_level = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      option    <= COC_REG_RESET;
      rdata_q   <= COC_READ_MISS;
      ptm_level <= 1'b0;
    end
    else
    begin
      option    <= next_option;
      rdata_q   <= next_rdata;
      ptm_level <= next_ptm_level;
    end
  end

  // ==========================================================
  // Comparator sense and deglitch
  logic cmp_active;
  logic raw_out;

  // Normal mode uses the main enable; low power needs its own
  always_comb
  begin
    cmp_active = comparator_enable;
    if (low_power_mode_enable)
    begin
      cmp_active = low_power_comparator_enable;
    end
  end
  // Polarity 0: above threshold drives low; 1: below drives low
  assign raw_out = option[COC_BIT_COMPARATOR_POLARITY] ? comparator_input
                                           : !comparator_input;
  // Idle comparator parks high so it never trips
  assign link.raw_level       = cmp_active ? raw_out : 1'b1;
  assign link.deglitch_cycles =
    deg_limit(coc_deg_t'(option[COC_BIT_DEG_HI:COC_BIT_DEG_LO]),
              low_power_mode_enable);

  coc_deglitch u_deglitch
  (
    .clock (clock),
    .rst_n (rst_n),
    .link  (link)
  );

  // ==========================================================
  // Ship discharge window
  // A register reset beats a same-cycle write: no fresh window
  logic dchg_start_req;
  logic dchg_stop_req;

  always_comb
  begin
    dchg_start_req = 1'b0;
    dchg_stop_req  = 1'b0;
    if (reg_reset)
    begin
      dchg_stop_req = 1'b1;
    end
    else if (ship_write_one)
    begin
      dchg_start_req = 1'b1;
    end
    else if (ship_write_zero)
    begin
      dchg_stop_req = 1'b1;
    end
  end

  assign link.dchg_start = dchg_start_req;
  assign link.dchg_stop  = dchg_stop_req;

  coc_dchg_timer #(
    .WINDOW_CYCLES (DCHG_LIMIT)
  ) u_dchg_timer
  (
    .clock (clock),
    .rst_n (rst_n),
    .link  (link)
  );

  // ==========================================================
  // Output logic
  logic       mode_ok;
  logic       force_off;
  logic       next_cmp_out;
  logic       next_switch_off;
  logic       next_charge_ok;
  logic [2:0] next_ovp;
  logic       next_sink;
  logic       next_short_prot;

  // Forward with adapter, or battery only outside low power
  always_comb
  begin
    mode_ok = 1'b0;
    if (forward_mode && adapter_present)
    begin
      mode_ok = 1'b1;
    end
    else if (!adapter_present && !low_power_mode_enable)
    begin
      mode_ok = 1'b1;
    end
    // Both the force bit and the main enable must be set
    force_off = 1'b0;
    if (option[COC_BIT_FORCE_OFF] && comparator_enable && mode_ok)
    begin
      force_off = !link.filtered_level;
    end
  end

  always_comb
  begin
    next_cmp_out    = link.filtered_level;
    next_switch_off = force_off;
    next_charge_ok  = charge_ok_source && !force_off;
    next_ovp        = cell_count_present_pin;
    if (option[COC_BIT_OVP_MAX])
    begin
      next_ovp = COC_OVP_SEL_27V;
    end
    // Sink stops at 0V but the window keeps running to its end
    next_sink = 1'b0;
    if (link.dchg_active && !sense_node_at_zero)
    begin
      next_sink = !link.dchg_stop;
    end
    next_short_prot = option[COC_BIT_SHORT_PROT];
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      comparator_output           <= 1'b1;
      input_high_side_switch_off  <= 1'b0;
      output_high_side_switch_off <= 1'b0;
      charge_ok_indication        <= 1'b0;
      system_overvoltage_protect  <= 3'h0;
      ship_discharge_sink         <= 1'b0;
      input_short_protect_enable  <= 1'b1;
    end
    else
    begin
      comparator_output           <= next_cmp_out;
      input_high_side_switch_off  <= next_switch_off;
      output_high_side_switch_off <= next_switch_off;
      charge_ok_indication        <= next_charge_ok;
      system_overvoltage_protect  <= next_ovp;
      ship_discharge_sink         <= next_sink;
      input_short_protect_enable  <= next_short_prot;
    end
  end

  assign reg_rdata         = rdata_q;
  assign pass_through_mode = ptm_level;

endmodule : coc_option_ctrl

// ---- design/coc_pkg.sv ----
// Constants for the charger option control register block
package coc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] COC_REG_OFFSET     = 8'h30;
  localparam logic [7:0] COC_REG_RESET      = 8'h01;
  localparam logic [7:0] COC_READ_MISS      = 8'h00;

  // ==========================================================
  // Field positions
  localparam int COC_BIT_OVP_MAX    = 7;
  localparam int COC_BIT_COMPARATOR_POLARITY    = 6;
  localparam int COC_BIT_DEG_HI     = 5;
  localparam int COC_BIT_DEG_LO     = 4;
  localparam int COC_BIT_FORCE_OFF  = 3;
  localparam int COC_BIT_PASS_THRU  = 2;
  localparam int COC_BIT_SHIP_DCHG  = 1;
  localparam int COC_BIT_SHORT_PROT = 0;

  // ==========================================================
  // Overvoltage threshold code that stands for the fixed 27V level
  localparam logic [2:0] COC_OVP_SEL_27V = 3'h7;

  // ==========================================================
  // Timing, figures in microseconds, clock in MHz
  localparam int CLK_MHZ            = 50;
  localparam int DEG_FAST_TIME_US   = 1;
  localparam int DEG_LP_TIME_US     = 40;
  localparam int DEG_MID_TIME_US    = 2050;
  localparam int DEG_SLOW_TIME_US   = 20850;
  localparam int DEG_LONG_TIME_US   = 5340000;
  localparam int SHIP_DCHG_TIME_US  = 340000;

  // Least times round up; whole microseconds never need it at 50 MHz
  localparam int DEG_FAST_CYCLES    = DEG_FAST_TIME_US * CLK_MHZ;
  localparam int DEG_LP_CYCLES      = DEG_LP_TIME_US * CLK_MHZ;
  localparam int DEG_MID_CYCLES     = DEG_MID_TIME_US * CLK_MHZ;
  localparam int DEG_SLOW_CYCLES    = DEG_SLOW_TIME_US * CLK_MHZ;
  localparam int DEG_LONG_CYCLES    = DEG_LONG_TIME_US * CLK_MHZ;
  localparam int SHIP_DCHG_CYCLES   = SHIP_DCHG_TIME_US * CLK_MHZ;

  // ==========================================================
  // Deglitch selector codes
  typedef enum logic [1:0]
  {
    COC_DEG_FAST = 2'b00,
    COC_DEG_MID  = 2'b01,
    COC_DEG_SLOW = 2'b10,
    COC_DEG_LONG = 2'b11
  } coc_deg_t;

endpackage : coc_pkg

// ---- design/coc_link_if.sv ----
// Links between the control register and its filter and timer
`timescale 1ns/1ps
interface coc_link_if;
  logic        raw_level;
  logic [31:0] deglitch_cycles;
  logic        filtered_level;
  logic        dchg_start;
  logic        dchg_stop;
  logic        dchg_active;
  logic        dchg_done;

  modport filter (input raw_level, input deglitch_cycles,
                  output filtered_level);
  modport filter_user (output raw_level, output deglitch_cycles,
                       input filtered_level);
  modport timer (input dchg_start, input dchg_stop,
                 output dchg_active, output dchg_done);
  modport timer_user (output dchg_start, output dchg_stop,
                      input dchg_active, input dchg_done);
endinterface : coc_link_if

// ---- design/coc_deglitch.sv ----
// Falling-edge deglitch filter for the comparator output
`timescale 1ns/1ps
module coc_deglitch
  import coc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  coc_link_if.filter link
);

  logic        level;
  logic        next_level;
  logic [31:0] count;
  logic [31:0] next_count;

  // ==========================================================
  // Rising edges pass at once, falling edges must persist
  always_comb
  begin
    next_level = level;
    next_count = count;
    if (link.raw_level)
    begin
      next_level = 1'b1;
      next_count = 32'h0;
    end
    else if (level)
    begin
      if (count + 32'h1 >= link.deglitch_cycles)
      begin
        next_level = 1'b0;
        next_count = 32'h0;
      end
      else
      begin
        next_count = count + 32'h1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      level <= 1'b1;
      count <= 32'h0;
    end
    else
    begin
      level <= next_level;
      count <= next_count;
    end
  end

  assign link.filtered_level = level;

endmodule : coc_deglitch

// ---- design/coc_dchg_timer.sv ----
// Window timer for the battery sense node discharge
`timescale 1ns/1ps
module coc_dchg_timer
  import coc_pkg::*;
#(
  parameter int WINDOW_CYCLES = SHIP_DCHG_CYCLES
)
(
  input  wire logic clock,
  input  wire logic rst_n,
  coc_link_if.timer link
);

  logic        active;
  logic        next_active;
  logic        done;
  logic        next_done;
  logic [31:0] count;
  logic [31:0] next_count;

  // ==========================================================
  // Start restarts from zero even mid-window
  always_comb
  begin
    next_active = active;
    next_count  = count;
    next_done   = 1'b0;
    if (link.dchg_start)
    begin
      next_active = 1'b1;
      next_count  = 32'h0;
    end
    else if (link.dchg_stop)
    begin
      next_active = 1'b0;
      next_count  = 32'h0;
    end
    else if (active)
    begin
      if (count + 32'h1 >= 32'(WINDOW_CYCLES))
      begin
        next_active = 1'b0;
        next_done   = 1'b1;
        next_count  = 32'h0;
      end
      else
      begin
        next_count = count + 32'h1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      active <= 1'b0;
      done   <= 1'b0;
      count  <= 32'h0;
    end
    else
    begin
      active <= next_active;
      done   <= next_done;
      count  <= next_count;
    end
  end

  assign link.dchg_active = active;
  assign link.dchg_done   = done;

endmodule : coc_dchg_timer

// ---- sim/coc_option_ctrl_props.sv ----
// Concurrent checks on the option control register ports
`timescale 1ns/1ps
module coc_option_ctrl_props
  import coc_pkg::*;
#(
  parameter int DCHG_LIMIT = SHIP_DCHG_CYCLES
)
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       reg_reset,
  input wire logic       reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       comparator_enable,
  input wire logic       low_power_mode_enable,
  input wire logic       forward_mode,
  input wire logic       adapter_present,
  input wire logic       charge_ok_source,
  input wire logic [2:0] cell_count_present_pin,
  input wire logic       pass_through_exit,
  input wire logic       sense_node_at_zero,
  input wire logic       input_high_side_switch_off,
  input wire logic       output_high_side_switch_off,
  input wire logic       charge_ok_indication,
  input wire logic [2:0] system_overvoltage_protect,
  input wire logic       pass_through_mode,
  input wire logic       ship_discharge_sink,
  input wire logic       input_short_protect_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic        wr_hit;
  logic [31:0] sink_run;
  logic [31:0] next_sink_run;
  assign wr_hit = reg_write && reg_addr == COC_REG_OFFSET && !reg_reset;
  // =========================================================
  // Sink length, restarted by a fresh ship write
  always_comb
  begin
    next_sink_run = 32'h0;
    if (ship_discharge_sink && !(wr_hit && reg_wdata[1]))
      next_sink_run = sink_run + 32'h1;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sink_run <= 32'h0;
    else
      sink_run <= next_sink_run;
  end
  chk_ovp_forced: assert property (
    (wr_hit && reg_wdata[7]) ##1 (!reg_write && !reg_reset)
    |=> system_overvoltage_protect == COC_OVP_SEL_27V)
    else $error("ovp threshold not forced");
  chk_ovp_pin: assert property (
    (wr_hit && !reg_wdata[7]) ##1 (!reg_write && !reg_reset)
    |=> system_overvoltage_protect == $past(cell_count_present_pin))
    else $error("ovp threshold not from pin");
  chk_short_copy: assert property (
    wr_hit ##1 (!reg_write && !reg_reset)
    |=> input_short_protect_enable == $past(reg_wdata[0], 2))
    else $error("short protect enable wrong");
  chk_sink_start: assert property (
    (wr_hit && reg_wdata[1])
    ##1 (!reg_write && !reg_reset && !sense_node_at_zero)
    |=> ship_discharge_sink)
    else $error("discharge did not start");
  chk_sink_stop: assert property (
    ship_discharge_sink && wr_hit && !reg_wdata[1]
    |=> !ship_discharge_sink)
    else $error("discharge not stopped by host");
  chk_zero_cutoff: assert property (
    sense_node_at_zero |=> !ship_discharge_sink)
    else $error("discharge kept at zero volts");
  chk_window_len: assert property (
    sink_run <= 32'(DCHG_LIMIT + 3))
    else $error("discharge window too long");
  chk_ptm_rise: assert property (
    (wr_hit && reg_wdata[2] && !pass_through_exit)
    ##1 (!pass_through_exit && !reg_reset)
    |=> pass_through_mode)
    else $error("pass-through not entered");
  chk_ptm_exit: assert property (
    pass_through_exit && !(wr_hit && reg_wdata[2])
    && !$past(wr_hit && reg_wdata[2])
    |=> !pass_through_mode)
    else $error("pass-through not left");
  chk_switch_pair: assert property (
    input_high_side_switch_off == output_high_side_switch_off)
    else $error("power switches disagree");
  chk_chg_ok: assert property (
    $past(rst_n, 2) |-> charge_ok_indication
    == ($past(charge_ok_source) && !input_high_side_switch_off))
    else $error("charge ok wrong");
  chk_force_cond: assert property (
    $rose(input_high_side_switch_off) |-> $past(comparator_enable
    && (forward_mode && adapter_present
    || !adapter_present && !low_power_mode_enable)))
    else $error("force off outside its modes");
endmodule : coc_option_ctrl_props
bind coc_option_ctrl coc_option_ctrl_props #(.DCHG_LIMIT(DCHG_LIMIT))
  u_props (.clock, .rst_n, .reg_reset, .reg_write, .reg_addr, .reg_wdata,
  .comparator_enable, .low_power_mode_enable, .forward_mode,
  .adapter_present, .charge_ok_source, .cell_count_present_pin,
  .pass_through_exit, .sense_node_at_zero, .input_high_side_switch_off,
  .output_high_side_switch_off, .charge_ok_indication,
  .system_overvoltage_protect, .pass_through_mode, .ship_discharge_sink,
  .input_short_protect_enable);

// ---- sim/coc_host.sv ----
// Host model that reads and writes the option register
`timescale 1ns/1ps
module coc_host
(
  input  wire logic       clock,
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines flip so a stale value cannot pass for a new one
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    reg_write = 1'b1;
    reg_addr  = addr;
    reg_wdata = data;
    @(negedge clock);
    reg_write = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask : wr
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    reg_read = 1'b1;
    reg_addr = addr;
    @(negedge clock);
    reg_read = 1'b0;
    reg_addr = ~addr;
    data     = reg_rdata;
  endtask : rd
endmodule : coc_host

// ---- sim/test_charger_option_control_reg.sv ----
// Self-checking bench for the option control register
`timescale 1ns/1ps
module test_charger_option_control_reg;
  import coc_pkg::*;
  localparam int MID = 20, SLOW = 30, LONG = 40, DCHG = 50;
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rback;
    logic [2:0] ovp;
    logic       sp;
  } coc_row_t;
  coc_row_t rows [5] = '{'{8'h30, 8'h80, 8'h80, 3'h7, 1'b0},
    '{8'h30, 8'h01, 8'h01, 3'h2, 1'b1}, '{8'h30, 8'h40, 8'h40, 3'h2, 1'b0},
    '{8'h31, 8'hFF, 8'h40, 3'h2, 1'b0}, '{8'h30, 8'hB1, 8'hB1, 3'h7, 1'b1}};
  int          degs [4] = '{DEG_FAST_CYCLES, MID, SLOW, LONG};
  logic        clock, rst_n, reg_reset, reg_write, reg_read;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rdata;
  logic        comparator_input, comparator_enable, low_power_mode_enable;
  logic        low_power_comparator_enable, forward_mode, adapter_present;
  logic        charge_ok_source, pass_through_exit, sense_node_at_zero;
  logic [2:0]  cell_count_present_pin, system_overvoltage_protect;
  logic        comparator_output, input_high_side_switch_off;
  logic        output_high_side_switch_off, charge_ok_indication;
  logic        pass_through_mode, ship_discharge_sink;
  logic        input_short_protect_enable;
  int          n_mismatch = 0;
  int          compares = 0;
  coc_option_ctrl #(.DEG_MID_LIMIT(MID), .DEG_SLOW_LIMIT(SLOW),
    .DEG_LONG_LIMIT(LONG), .DCHG_LIMIT(DCHG)) DUT (.clock, .rst_n,
    .reg_reset, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
    .comparator_input, .comparator_enable, .low_power_mode_enable,
    .low_power_comparator_enable, .forward_mode, .adapter_present,
    .charge_ok_source, .cell_count_present_pin, .pass_through_exit,
    .sense_node_at_zero, .comparator_output, .input_high_side_switch_off,
    .output_high_side_switch_off, .charge_ok_indication,
    .system_overvoltage_protect, .pass_through_mode, .ship_discharge_sink,
    .input_short_protect_enable);
  coc_host host (.clock, .reg_write, .reg_read, .reg_addr, .reg_wdata,
    .reg_rdata);
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  task automatic chk_byte(input string name, input logic [7:0] exp,
                          input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // =========================================================
  // Trip the comparator with deglitch code and its polarity
  task automatic trip(input logic [1:0] code, input int deg);
    comparator_input = code[0];
    host.wr(COC_REG_OFFSET, {2'b00, code, 4'h0} | {1'b0, code[0], 6'h0});
    cyc(4);
    comparator_input = !code[0];
    cyc(deg);
    chk_bit("comparator_output", 1'b1, comparator_output);
    cyc(1);
    chk_bit("comparator_output", 1'b0, comparator_output);
    comparator_input = code[0];
    cyc(3);
    chk_bit("comparator_output", 1'b1, comparator_output);
  endtask : trip
  task automatic tally_and_finish;
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    {rst_n, reg_reset, comparator_input, comparator_enable} = 4'h0;
    {low_power_mode_enable, low_power_comparator_enable} = 2'b00;
    {forward_mode, adapter_present, charge_ok_source} = 3'b111;
    {pass_through_exit, sense_node_at_zero} = 2'b00;
    cell_count_present_pin = 3'h2;
    cyc(8);
    rst_n = 1'b1;
    chk_byte("reg_rdata", 8'h00, reg_rdata);
    chk_bit("ship_discharge_sink", 1'b0, ship_discharge_sink);
    chk_bit("comparator_output", 1'b1, comparator_output);
    chk_bit("charge ok", 1'b0, charge_ok_indication);
    host.rd(COC_REG_OFFSET, rdata);
    chk_byte("option register", COC_REG_RESET, rdata);
    chk_bit("short protect", 1'b1, input_short_protect_enable);
    foreach (rows[i])
    begin
      host.wr(rows[i].addr, rows[i].wdata);
      host.rd(COC_REG_OFFSET, rdata);
      chk_byte("option register", rows[i].rback, rdata);
      chk_byte("ovp", {5'h0, rows[i].ovp},
               {5'h0, system_overvoltage_protect});
      chk_bit("short protect", rows[i].sp,
              input_short_protect_enable);
    end
    host.rd(8'h31, rdata);
    chk_byte("unmapped read", COC_READ_MISS, rdata);
    comparator_enable = 1'b1;
    for (int c = 0; c < 4; c++)
      trip(2'(c), degs[c]);
    {comparator_enable, adapter_present} = 2'b00;
    {low_power_mode_enable, low_power_comparator_enable} = 2'b11;
    trip(2'b00, DEG_LP_CYCLES);
    {low_power_mode_enable, low_power_comparator_enable} = 2'b00;
    {comparator_enable, adapter_present} = 2'b11;
    host.wr(COC_REG_OFFSET, 8'h08);
    cyc(4);
    comparator_input = 1'b1;
    cyc(55);
    chk_bit("switch off", 1'b1, input_high_side_switch_off);
    chk_bit("charge ok", 1'b0, charge_ok_indication);
    comparator_input = 1'b0;
    forward_mode = 1'b0;
    cyc(5);
    comparator_input = 1'b1;
    cyc(55);
    chk_bit("switch off", 1'b0, input_high_side_switch_off);
    chk_bit("charge ok", 1'b1, charge_ok_indication);
    comparator_input = 1'b0;
    host.wr(COC_REG_OFFSET, 8'h04);
    cyc(2);
    chk_bit("pass_through_mode", 1'b1, pass_through_mode);
    host.rd(COC_REG_OFFSET, rdata);
    chk_byte("option register", 8'h00, rdata);
    pass_through_exit = 1'b1;
    cyc(2);
    chk_bit("pass_through_mode", 1'b0, pass_through_mode);
    pass_through_exit = 1'b0;
    host.wr(COC_REG_OFFSET, 8'h02);
    cyc(DCHG);
    chk_bit("ship_discharge_sink", 1'b1, ship_discharge_sink);
    cyc(1);
    chk_bit("ship_discharge_sink", 1'b0, ship_discharge_sink);
    host.rd(COC_REG_OFFSET, rdata);
    chk_byte("option register", 8'h00, rdata);
    host.wr(COC_REG_OFFSET, 8'h02);
    cyc(30);
    host.wr(COC_REG_OFFSET, 8'h02);
    cyc(30);
    chk_bit("ship_discharge_sink", 1'b1, ship_discharge_sink);
    host.wr(COC_REG_OFFSET, 8'h00);
    cyc(1);
    chk_bit("ship_discharge_sink", 1'b0, ship_discharge_sink);
    host.wr(COC_REG_OFFSET, 8'h02);
    cyc(3);
    sense_node_at_zero = 1'b1;
    cyc(2);
    chk_bit("ship_discharge_sink", 1'b0, ship_discharge_sink);
    host.rd(COC_REG_OFFSET, rdata);
    chk_byte("option register", 8'h02, rdata);
    sense_node_at_zero = 1'b0;
    host.wr(COC_REG_OFFSET, 8'h82);
    cyc(3);
    reg_reset = 1'b1;
    cyc(2);
    chk_bit("ship_discharge_sink", 1'b0, ship_discharge_sink);
    reg_reset = 1'b0;
    host.rd(COC_REG_OFFSET, rdata);
    chk_byte("option register", COC_REG_RESET, rdata);
    reg_reset = 1'b1;
    host.wr(COC_REG_OFFSET, 8'h02);
    reg_reset = 1'b0;
    cyc(3);
    chk_bit("ship_discharge_sink", 1'b0, ship_discharge_sink);
    tally_and_finish();
  end
endmodule : test_charger_option_control_reg
